/* File: src/tps_scheduler.sv */
// Transmit process-data slot scheduler with APB register access.
// Assumes application values arrive on pclk; frame port feeds a CAN controller.
//
// What this block does
// - Eight transmit slots with own records
// - Only slots one to three exist after reset
// - Base 11-bit frames, no remote answers
// - Period 100 ms slots 1-3, else zero
// - Periodic send when operational, existing, nonzero period
// - Default identifiers from base plus node
// - Top identifier bit set blocks sending
// - Flag bit marks remote requests refused
// - Reset flags 40000000h or C0000000h
// - Node change recomputes every identifier
// - Transmission type reads fixed 254
// - Slot one maps analog inputs 1-4
// - Slot two maps inputs 5-7, digital 8
// - Slot three maps output feedback values
// - Slot four maps eight digital inputs
// - Slot five maps analog output values
// - Slot six maps four controller outputs
// - Slot seven maps supply value only
// - Slot eight maps nothing
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module tps_scheduler #(
  parameter int PERIOD_UNIT_CYC = tps_pkg::TPS_PERIOD_UNIT_CYC,
  parameter int INHIBIT_UNIT_CYC = tps_pkg::TPS_INHIBIT_UNIT_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Application values
  input wire logic [6:0][15:0] ai_field,
  input wire logic [7:0] di_state,
  input wire logic [3:0][15:0] ao_feedback,
  input wire logic [3:0][15:0] ao_field,
  input wire logic [3:0][15:0] pid_out,
  input wire logic [31:0] supply_field,
  // Frame to CAN controller
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [10:0] tx_id,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data
);

  // ****************************************
  // Storage
  // ****************************************
  logic [31:0] id_r [tps_pkg::TPS_SLOTS];
  logic [15:0] inhibit_r [tps_pkg::TPS_SLOTS];
  logic [7:0] compat_r [tps_pkg::TPS_SLOTS];
  logic [15:0] period_r [tps_pkg::TPS_SLOTS];
  logic [3:0] map_cnt_r [tps_pkg::TPS_SLOTS];
  logic [31:0] map_r [tps_pkg::TPS_SLOTS*tps_pkg::TPS_MAP_MAX];
  logic [6:0] node_r;
  logic oper_r;
  logic [15:0] per_cnt_r [tps_pkg::TPS_SLOTS];
  logic [15:0] inh_cnt_r [tps_pkg::TPS_SLOTS];
  logic [7:0] pend_r;
  logic [7:0] fire;
  logic [7:0] eligible;
  logic [7:0] sent;
  logic [7:0] per_wr;
  logic [31:0] per_pre_r;
  logic [31:0] inh_pre_r;
  logic per_tick;
  logic inh_tick;
  tps_pkg::tps_state_t st_r;
  logic [2:0] cur_r;
  logic [3:0] ent_r;
  logic [6:0] bitpos_r;
  logic [63:0] data_r;

  // ****************************************
  // APB decode
  // ****************************************
  // One wait state so read data leaves a flip-flop
  logic acc_r;
  logic wr_en;
  logic is_global;
  logic [2:0] a_slot;
  logic [4:0] a_ix;
  logic a_ok;
  logic [31:0] rd_val;

  assign is_global = paddr[tps_pkg::TPS_GLOBAL_BIT];
  assign a_slot = paddr[9:7];
  assign a_ix = paddr[6:2];
  assign pready = acc_r;
  assign wr_en = psel & penable & pwrite & acc_r & a_ok;

  always_comb begin
    a_ok = 1'b0;
    rd_val = 32'h00000000;
    if (is_global) begin
      unique case (a_ix)
        tps_pkg::TPS_GL_NODE: begin
          a_ok = 1'b1;
          rd_val = {25'h0, node_r};
        end
        tps_pkg::TPS_GL_CTRL: begin
          a_ok = 1'b1;
          rd_val = {31'h0, oper_r};
        end
        tps_pkg::TPS_GL_STAT: begin
          a_ok = 1'b1;
          rd_val = {23'h0, st_r != tps_pkg::TPS_ST_IDLE, pend_r};
        end
        default: a_ok = 1'b0;
      endcase
    end else if (a_ix >= tps_pkg::TPS_IX_MAP_FIRST && a_ix <= tps_pkg::TPS_IX_MAP_LAST) begin
      a_ok = 1'b1;
      rd_val = map_r[{a_slot, 3'(a_ix - tps_pkg::TPS_IX_MAP_FIRST)}];
    end else begin
      a_ok = 1'b1;
      unique case (a_ix)
        tps_pkg::TPS_IX_COUNT: rd_val = {24'h0, tps_pkg::TPS_ENTRY_COUNT};
        tps_pkg::TPS_IX_ID: rd_val = id_r[a_slot];
        tps_pkg::TPS_IX_TTYPE: rd_val = {24'h0, tps_pkg::TPS_TTYPE};
        tps_pkg::TPS_IX_INHIBIT: rd_val = {16'h0, inhibit_r[a_slot]};
        tps_pkg::TPS_IX_COMPAT: rd_val = {24'h0, compat_r[a_slot]};
        tps_pkg::TPS_IX_PERIOD: rd_val = {16'h0, period_r[a_slot]};
        tps_pkg::TPS_IX_MAP_CNT: rd_val = {28'h0, map_cnt_r[a_slot]};
        default: a_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && penable && !acc_r) begin
      acc_r <= 1'b1;
      prdata <= pwrite ? 32'h00000000 : rd_val;
      pslverr <= !a_ok;
    end else begin
      acc_r <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_r <= tps_pkg::TPS_NODE_RST;
      oper_r <= 1'b0;
    end else if (wr_en && is_global) begin
      if (a_ix == tps_pkg::TPS_GL_NODE) begin
        node_r <= pwdata[6:0];
      end
      if (a_ix == tps_pkg::TPS_GL_CTRL) begin
        oper_r <= pwdata[tps_pkg::TPS_OPER_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < tps_pkg::TPS_SLOTS; s++) begin
        id_r[s] <= (tps_pkg::TPS_EXISTS_RST[s] ? tps_pkg::TPS_ID_FLAGS_ON
          : tps_pkg::TPS_ID_FLAGS_OFF) | {21'h0, 11'(tps_pkg::TPS_ID_BASE[s]
          + {4'h0, tps_pkg::TPS_NODE_RST})};
        inhibit_r[s] <= tps_pkg::TPS_INHIBIT_RST;
        compat_r[s] <= tps_pkg::TPS_COMPAT_RST;
        period_r[s] <= tps_pkg::TPS_PERIOD_RST[s];
        map_cnt_r[s] <= tps_pkg::TPS_MAP_CNT_RST[s];
      end
      for (int m = 0; m < tps_pkg::TPS_SLOTS * tps_pkg::TPS_MAP_MAX; m++) begin
        map_r[m] <= tps_pkg::TPS_MAP_RST[m];
      end
    end else if (wr_en && is_global && a_ix == tps_pkg::TPS_GL_NODE) begin
      for (int s = 0; s < tps_pkg::TPS_SLOTS; s++) begin
        id_r[s] <= {id_r[s][31:11], 11'(tps_pkg::TPS_ID_BASE[s] + {4'h0, pwdata[6:0]})};
      end
    end else if (wr_en && !is_global) begin
      if (a_ix >= tps_pkg::TPS_IX_MAP_FIRST && a_ix <= tps_pkg::TPS_IX_MAP_LAST) begin
        map_r[{a_slot, 3'(a_ix - tps_pkg::TPS_IX_MAP_FIRST)}] <= pwdata;
      end
      unique case (a_ix)
        tps_pkg::TPS_IX_ID: id_r[a_slot] <= pwdata;
        tps_pkg::TPS_IX_INHIBIT: inhibit_r[a_slot] <= pwdata[15:0];
        tps_pkg::TPS_IX_COMPAT: compat_r[a_slot] <= pwdata[7:0];
        tps_pkg::TPS_IX_PERIOD: period_r[a_slot] <= pwdata[15:0];
        tps_pkg::TPS_IX_MAP_CNT: map_cnt_r[a_slot] <= (pwdata[7:0] > 8'h08) ? 4'h8
          : pwdata[3:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Time base
  // ****************************************
  assign per_tick = per_pre_r == 32'(PERIOD_UNIT_CYC - 1);
  assign inh_tick = inh_pre_r == 32'(INHIBIT_UNIT_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_pre_r <= 32'h00000000;
    end else begin
      per_pre_r <= per_tick ? 32'h00000000 : per_pre_r + 32'h00000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inh_pre_r <= 32'h00000000;
    end else begin
      inh_pre_r <= inh_tick ? 32'h00000000 : inh_pre_r + 32'h00000001;
    end
  end

  // ****************************************
  // Per-slot timers
  // ****************************************
  generate
    for (genvar g = 0; g < tps_pkg::TPS_SLOTS; g++) begin : g_slot
      logic exists;
      assign exists = !id_r[g][tps_pkg::TPS_ID_OFF_BIT];
      assign per_wr[g] = wr_en && !is_global && a_slot == 3'(g)
        && a_ix == tps_pkg::TPS_IX_PERIOD;
      assign fire[g] = per_tick && oper_r && exists && period_r[g] != 16'h0000
        && per_cnt_r[g] <= 16'h0001 && !per_wr[g];
      assign eligible[g] = pend_r[g] && exists && inh_cnt_r[g] == 16'h0000;
      assign sent[g] = st_r == tps_pkg::TPS_ST_SEND && tx_ready && cur_r == 3'(g);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          per_cnt_r[g] <= 16'h0000;
        end else if (per_wr[g]) begin
          per_cnt_r[g] <= pwdata[15:0];
        end else if (!oper_r || fire[g]) begin
          per_cnt_r[g] <= period_r[g];
        end else if (per_tick && per_cnt_r[g] != 16'h0000) begin
          per_cnt_r[g] <= per_cnt_r[g] - 16'h0001;
        end
      end

      // Expiry wins over a send in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend_r[g] <= 1'b0;
        end else if (fire[g]) begin
          pend_r[g] <= 1'b1;
        end else if (sent[g] || !oper_r) begin
          pend_r[g] <= 1'b0;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          inh_cnt_r[g] <= 16'h0000;
        end else if (sent[g]) begin
          inh_cnt_r[g] <= inhibit_r[g];
        end else if (inh_tick && inh_cnt_r[g] != 16'h0000) begin
          inh_cnt_r[g] <= inh_cnt_r[g] - 16'h0001;
        end
      end
    end
  endgenerate

  // ****************************************
  // Object lookup
  // ****************************************
  function automatic logic [31:0] obj_value(input logic [31:0] e);
    logic [7:0] sub;
    logic [2:0] k;
    sub = e[15:8];
    k = 3'(sub - 8'h01);
    obj_value = 32'h00000000;
    if (e[31:16] == tps_pkg::TPS_OBJ_SUPPLY) begin
      obj_value = supply_field;
    end else if (e[31:16] == tps_pkg::TPS_OBJ_DI && sub >= 8'h01 && sub <= 8'h08) begin
      obj_value = {31'h0, di_state[k]};
    end else if (e[31:16] == tps_pkg::TPS_OBJ_AI_FV && sub >= 8'h01 && sub <= 8'h07) begin
      obj_value = {16'h0, ai_field[k]};
    end else if (sub >= 8'h01 && sub <= 8'h04) begin
      if (e[31:16] == tps_pkg::TPS_OBJ_AO_FB) begin
        obj_value = {16'h0, ao_feedback[k[1:0]]};
      end else if (e[31:16] == tps_pkg::TPS_OBJ_AO_FV) begin
        obj_value = {16'h0, ao_field[k[1:0]]};
      end else if (e[31:16] == tps_pkg::TPS_OBJ_PID) begin
        obj_value = {16'h0, pid_out[k[1:0]]};
      end
    end
  endfunction

  // ****************************************
  // Frame assembly
  // ****************************************
  logic [2:0] pick;
  logic any_elig;
  logic [31:0] cur_ent;
  logic [7:0] cur_len;
  logic [31:0] cur_mask;
  logic [127:0] shifted;
  logic [8:0] end_pos;

  always_comb begin
    pick = 3'h0;
    any_elig = 1'b0;
    for (int s = tps_pkg::TPS_SLOTS - 1; s >= 0; s--) begin
      if (eligible[s]) begin
        pick = 3'(s);
        any_elig = 1'b1;
      end
    end
  end

  assign cur_ent = map_r[{cur_r, ent_r[2:0]}];
  assign cur_len = cur_ent[7:0];
  assign cur_mask = (cur_len >= 8'h20) ? 32'hFFFFFFFF : (32'h00000001 << cur_len) - 32'h00000001;
  assign shifted = {96'h0, obj_value(cur_ent) & cur_mask} << bitpos_r;
  assign end_pos = {2'b00, bitpos_r} + {1'b0, cur_len};
  // base frame only, no remote requests
  assign tx_valid = st_r == tps_pkg::TPS_ST_SEND;

  // An entry that no longer fits is dropped rather than truncated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= tps_pkg::TPS_ST_IDLE;
      cur_r <= 3'h0;
      ent_r <= 4'h0;
      bitpos_r <= 7'h00;
      data_r <= 64'h0;
      tx_id <= 11'h000;
      tx_dlc <= 4'h0;
      tx_data <= 64'h0;
    end else begin
      unique case (st_r)
        tps_pkg::TPS_ST_IDLE: begin
          if (any_elig) begin
            st_r <= tps_pkg::TPS_ST_BUILD;
            cur_r <= pick;
            ent_r <= 4'h0;
            bitpos_r <= 7'h00;
            data_r <= 64'h0;
          end
        end
        tps_pkg::TPS_ST_BUILD: begin
          if (ent_r >= map_cnt_r[cur_r]) begin
            st_r <= tps_pkg::TPS_ST_SEND;
            tx_id <= id_r[cur_r][10:0];
            tx_dlc <= 4'(bitpos_r >> 3);
            tx_data <= data_r;
          end else begin
            ent_r <= ent_r + 4'h1;
            if (end_pos <= 9'd64) begin
              data_r <= data_r | shifted[63:0];
              bitpos_r <= end_pos[6:0];
            end
          end
        end
        tps_pkg::TPS_ST_SEND: begin
          if (tx_ready) begin
            st_r <= tps_pkg::TPS_ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule

/* File: src/tps_pkg.sv */
// Constants, register map and reset images of the transmit slot scheduler.
// Assumes a 250 MHz register clock shared by the bus and the scheduler.
package tps_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int TPS_SLOTS = 8;
  localparam int TPS_MAP_MAX = 8;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [4:0] TPS_IX_COUNT = 5'h00;
  localparam logic [4:0] TPS_IX_ID = 5'h01;
  localparam logic [4:0] TPS_IX_TTYPE = 5'h02;
  localparam logic [4:0] TPS_IX_INHIBIT = 5'h03;
  localparam logic [4:0] TPS_IX_COMPAT = 5'h04;
  localparam logic [4:0] TPS_IX_PERIOD = 5'h05;
  localparam logic [4:0] TPS_IX_MAP_CNT = 5'h10;
  localparam logic [4:0] TPS_IX_MAP_FIRST = 5'h11;
  localparam logic [4:0] TPS_IX_MAP_LAST = 5'h18;
  localparam logic [4:0] TPS_GL_NODE = 5'h00;
  localparam logic [4:0] TPS_GL_CTRL = 5'h01;
  localparam logic [4:0] TPS_GL_STAT = 5'h02;
  localparam int TPS_GLOBAL_BIT = 10;
  localparam int TPS_OPER_BIT = 0;
  localparam int TPS_BUSY_BIT = 8;

  // ****************************************
  // Fixed values and reset images
  // ****************************************
  localparam logic [7:0] TPS_ENTRY_COUNT = 8'h05;
  localparam logic [7:0] TPS_TTYPE = 8'hFE;
  localparam int TPS_ID_OFF_BIT = 31;
  localparam int TPS_ID_NORTR_BIT = 30;
  localparam logic [31:0] TPS_ID_FLAGS_ON = 32'h40000000;
  localparam logic [31:0] TPS_ID_FLAGS_OFF = 32'hC0000000;
  localparam logic [6:0] TPS_NODE_RST = 7'h01;
  localparam logic [10:0] TPS_ID_BASE [TPS_SLOTS] = '{11'h180, 11'h280, 11'h380, 11'h480,
    11'h181, 11'h281, 11'h381, 11'h481};
  localparam logic [7:0] TPS_EXISTS_RST = 8'h07;
  localparam logic [15:0] TPS_PERIOD_RST [TPS_SLOTS] = '{16'h0064, 16'h0064, 16'h0064,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] TPS_INHIBIT_RST = 16'h0000;
  localparam logic [7:0] TPS_COMPAT_RST = 8'h00;
  localparam logic [3:0] TPS_MAP_CNT_RST [TPS_SLOTS] = '{4'h4, 4'h4, 4'h4, 4'h8,
    4'h4, 4'h4, 4'h1, 4'h0};
  localparam logic [31:0] TPS_MAP_RST [TPS_SLOTS*TPS_MAP_MAX] = '{
    32'h71000110, 32'h71000210, 32'h71000310, 32'h71000410, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h71000510, 32'h71000610, 32'h71000710, 32'h60200808, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h23700110, 32'h23700210, 32'h23700310, 32'h23700410, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h60200108, 32'h60200208, 32'h60200308, 32'h60200408,
    32'h60200508, 32'h60200608, 32'h60200708, 32'h60200808,
    32'h73300110, 32'h73300210, 32'h73300310, 32'h73300410, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h24600110, 32'h24600210, 32'h24600310, 32'h24600410, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h50100020, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  // ****************************************
  // Mappable application objects
  // ****************************************
  localparam logic [15:0] TPS_OBJ_AI_FV = 16'h7100;
  localparam logic [15:0] TPS_OBJ_DI = 16'h6020;
  localparam logic [15:0] TPS_OBJ_AO_FB = 16'h2370;
  localparam logic [15:0] TPS_OBJ_AO_FV = 16'h7330;
  localparam logic [15:0] TPS_OBJ_PID = 16'h2460;
  localparam logic [15:0] TPS_OBJ_SUPPLY = 16'h5010;

  // ****************************************
  // Timing
  // ****************************************
  localparam int TPS_CLK_MHZ = 250;
  localparam int TPS_PERIOD_UNIT_US = 1000;
  localparam int TPS_INHIBIT_UNIT_US = 100;
  localparam int TPS_PERIOD_UNIT_CYC = TPS_CLK_MHZ * TPS_PERIOD_UNIT_US;
  localparam int TPS_INHIBIT_UNIT_CYC = TPS_CLK_MHZ * TPS_INHIBIT_UNIT_US;

  typedef enum logic [1:0] {TPS_ST_IDLE, TPS_ST_BUILD, TPS_ST_SEND} tps_state_t;

endpackage

/* File: verification/tps_scheduler_asserts.sv */
// Checker for the transmit slot scheduler ports.
// Assumes one pclk domain; bound to every scheduler instance.
`timescale 1ns/1ps
module tps_scheduler_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Frame
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [10:0] tx_id,
  input wire logic [3:0] tx_dlc,
  input wire logic [63:0] tx_data
);
  // ****************************************
  // Decode
  // ****************************************
  logic unmapped;
  logic cfg_rd;
  // Slot holes and global words past status
  assign unmapped = !paddr[11] && (paddr[10] ? paddr[6:2] > 5'h02 :
    paddr[6:2] inside {[5'h06:5'h0F], [5'h19:5'h1F]});
  assign cfg_rd = pready && !pwrite && !paddr[11] && !paddr[10];

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence

  a_one_wait:
    assert property ($rose(penable) && psel |-> s_wait ##1 s_answer)
    else $error("pready not in second access cycle");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready held too long");
  a_err_ready:
    assert property (pslverr |-> pready && psel && penable) else $error("stray pslverr");
  a_err_unmapped:
    assert property (pready && unmapped |-> pslverr) else $error("unmapped not refused");
  a_ok_mapped:
    assert property (pready && !unmapped && !paddr[11] |-> !pslverr)
    else $error("mapped access refused");
  a_ttype_fixed:
    assert property (cfg_rd && paddr[6:2] == 5'h02 |-> prdata == 32'h000000FE)
    else $error("transmission type wrong");
  a_count_fixed:
    assert property (cfg_rd && paddr[6:2] == 5'h00 |-> prdata == 32'h00000005)
    else $error("entry count wrong");
  a_write_zero:
    assert property (pready && pwrite |-> prdata == 32'h0) else $error("write read data");
  a_frame_hold:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_id) &&
      $stable(tx_dlc) && $stable(tx_data)) else $error("frame changed while offered");
  a_frame_drop:
    assert property (tx_valid && tx_ready |=> !tx_valid) else $error("frame not dropped");
  a_dlc_range:
    assert property (tx_valid |-> tx_dlc <= 4'h8) else $error("length above eight");
endmodule

bind tps_scheduler tps_scheduler_asserts u_tps_scheduler_asserts (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .tx_valid, .tx_ready, .tx_id,
  .tx_dlc, .tx_data);

/* File: verification/tps_can_sink.sv */
// CAN controller model taking frames from the scheduler.
// Assumes frames are recorded in acceptance order for the bench to inspect.
`timescale 1ns/1ps
module tps_can_sink (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Frame
  input wire logic tx_valid,
  input wire logic [10:0] tx_id,
  input wire logic [3:0] tx_dlc,
  input wire logic [63:0] tx_data,
  output logic tx_ready
);
  // ****************************************
  // Acceptance
  // ****************************************
  logic [1:0] cnt_r;
  logic [78:0] frames[$];
  // Stalls one cycle in four so offers must wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      tx_ready <= (cnt_r != 2'h3);
    end
  end
  always @(posedge pclk) begin
    if (presetn && tx_valid && tx_ready) frames.push_back({tx_id, tx_dlc, tx_data});
  end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the transmit slot scheduler.
// Assumes shortened time units: one period unit is 10 cycles.
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic tx_valid, tx_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, supply_field;
  logic [6:0][15:0] ai_field;
  logic [7:0] di_state;
  logic [3:0][15:0] ao_feedback, ao_field, pid_out;
  logic [10:0] tx_id;
  logic [3:0] tx_dlc;
  logic [63:0] tx_data, d;
  int mismatches, checked, cyc;
  localparam int MAP_CNT [8] = '{4, 4, 4, 8, 4, 4, 1, 0};

  tps_scheduler #(.PERIOD_UNIT_CYC(10), .INHIBIT_UNIT_CYC(5)) u_tps_scheduler (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ai_field, .di_state, .ao_feedback, .ao_field, .pid_out, .supply_field, .tx_valid,
    .tx_ready, .tx_id, .tx_dlc, .tx_data);
  tps_can_sink u_tps_can_sink (.pclk, .presetn, .tx_valid, .tx_id, .tx_dlc, .tx_data,
    .tx_ready);

  // ****************************************
  // Helpers
  // ****************************************
  task test_done;
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] x);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value at %0t got %h expected %h", $time, g, x);
    end
  endtask
  // Request held until pready is sampled high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(64'(r), 64'(x));
  endtask
  task wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask
  function automatic int find(input logic [10:0] id);
    for (int i = 0; i < u_tps_can_sink.frames.size(); i++) begin
      if (u_tps_can_sink.frames[i][78:68] === id) return i;
    end
    return -1;
  endfunction
  function automatic int cnt(input logic [10:0] id);
    int n;
    n = 0;
    for (int i = 0; i < u_tps_can_sink.frames.size(); i++) begin
      if (u_tps_can_sink.frames[i][78:68] === id) n++;
    end
    return n;
  endfunction
  task frm(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] x);
    int i;
    i = find(id);
    chk(64'(i >= 0), 64'h1);
    if (i >= 0) begin
      chk(64'(u_tps_can_sink.frames[i][67:64]), 64'(dlc));
      chk(u_tps_can_sink.frames[i][63:0], x);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    logic [11:0] a;
    logic [31:0] f;
    for (int s = 0; s < 8; s++) begin
      a = 12'(s * 128);
      f = (s < 3) ? 32'h40000000 : 32'hC0000000;
      rd(a, 32'h5);
      rd(a + 12'h008, 32'hFE);
      rd(a + 12'h004, f | 32'(11'h181 + 11'((s % 4) * 256 + s / 4)));
      rd(a + 12'h00C, 32'h0);
      rd(a + 12'h010, 32'h0);
      rd(a + 12'h014, (s < 3) ? 32'h64 : 32'h0);
      rd(a + 12'h040, 32'(MAP_CNT[s]));
      for (int j = 0; j < 8; j++) begin
        rd(a + 12'h044 + 12'(4 * j), tps_pkg::TPS_MAP_RST[s * 8 + j]);
      end
    end
  endtask
  task t_access;
    wr(12'h008, 32'h12);
    rd(12'h008, 32'hFE);
    apb(1'b0, 12'h018, 32'h0);
    chk(64'(e), 64'h1);
    chk(64'(r), 64'h0);
    // Slot eight stays absent, so its count can be reused here
    wr(12'h3C0, 32'h9);
    rd(12'h3C0, 32'h8);
  endtask
  task t_send;
    wr(12'h184, 32'h40000481);
    wr(12'h194, 32'h1);
    wr(12'h214, 32'h1);
    wr(12'h404, 32'h1);
    // Slots one to three fire after one full period
    repeat (1300) @(posedge pclk);
    // Without a restart slot one would wait about 700 more cycles
    wr(12'h014, 32'h1);
    repeat (60) @(posedge pclk);
    chk(64'(cnt(11'h181) > 1), 64'h1);
    wr(12'h404, 32'h0);
    for (int k = 0; k < 8; k++) d[8 * k +: 8] = {7'h0, di_state[k]};
    frm(11'h481, 4'h8, d);
    frm(11'h181, 4'h8, {ai_field[3], ai_field[2], ai_field[1], ai_field[0]});
    frm(11'h281, 4'h7, {15'h0, di_state[7], ai_field[6], ai_field[5], ai_field[4]});
    frm(11'h381, 4'h8, {ao_feedback[3], ao_feedback[2], ao_feedback[1], ao_feedback[0]});
    chk(64'(find(11'h182) < 0), 64'h1);
    chk(64'(find(11'h282) < 0), 64'h1);
    chk(64'(find(11'h181) < find(11'h281)), 64'h1);
  endtask
  task t_node;
    wr(12'h400, 32'h5);
    rd(12'h004, 32'h40000185);
    rd(12'h184, 32'h40000485);
    rd(12'h384, 32'hC0000486);
  endtask

  // ****************************************
  // Run
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done;
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    di_state = 8'hA5;
    supply_field = 32'h5A5A0001;
    for (int k = 0; k < 7; k++) ai_field[k] = 16'(16'h1100 * (k + 1));
    for (int k = 0; k < 4; k++) begin
      ao_feedback[k] = 16'(16'h2200 + k);
      ao_field[k] = 16'(16'h3300 + k);
      pid_out[k] = 16'(16'h4400 + k);
    end
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_access;
    t_send;
    t_node;
    test_done;
  end
endmodule
